// ---- design/lsec_defines.svh ----
// Offsets, field positions, reset values and timing figures of the LIN slave core
`ifndef LSEC_DEFINES_SVH
`define LSEC_DEFINES_SVH
// Direct SFR addresses
`define LSEC_SFR_DATA 8'hD2
`define LSEC_SFR_PTR 8'hD3
`define LSEC_SFR_CFG 8'hC9
// Indirect core addresses
`define LSEC_A_DBUF_LAST 8'h07
`define LSEC_A_CTRL 8'h08
`define LSEC_A_STAT 8'h09
`define LSEC_A_ERR 8'h0A
`define LSEC_A_SIZE 8'h0B
`define LSEC_A_DIV 8'h0C
`define LSEC_A_MUL 8'h0D
`define LSEC_A_ID 8'h0E
// Mode register fields
`define LSEC_CFG_EN 7
`define LSEC_CFG_MODE 6
`define LSEC_CFG_AUTO_BAUD_SELECT 5
`define LSEC_CFG_MASK 8'hE0
`define LSEC_CFG_RST 8'h60
// Control register fields
`define LSEC_CT_STOP 7
`define LSEC_CT_SLEEP 6
`define LSEC_CT_DIRECTION_SELECT 5
`define LSEC_CT_DATA_ACK_BIT 4
`define LSEC_CT_CLEAR_INTERRUPT_BIT 3
`define LSEC_CT_CLEAR_ERRORS_BIT 2
`define LSEC_CT_WAKE_REQUEST_BIT 1
`define LSEC_CT_MASK 8'h60
// Status register fields
`define LSEC_ST_ACTIVE 7
`define LSEC_ST_IDL 6
`define LSEC_ST_DATA_REQUEST_FLAG 4
`define LSEC_ST_INT 3
`define LSEC_ST_ERROR 2
`define LSEC_ST_WAKEUP 1
`define LSEC_ST_DONE 0
// Error register fields
`define LSEC_ER_SYNCH 4
`define LSEC_ER_PRTY 3
`define LSEC_ER_TIMEOUT_ERROR_BIT 2
`define LSEC_ER_CHK 1
`define LSEC_ER_BIT 0
// Size register fields
`define LSEC_SZ_ENH 7
`define LSEC_SZ_DECODE 4'hF
// Frame figures
`define LSEC_BRK_BITS 4'hB
`define LSEC_SYNC_PAT 8'h55
`define LSEC_SYNC_FALLS 3'h4
`define LSEC_CSUM_OK 8'hFF
// Timing figures
`define LSEC_CLK_MHZ 100
`define LSEC_IDLE_S 4
`define LSEC_WRESP_MS 150
`define LSEC_WTX_US 250
`define LSEC_WDET_US 150
`endif

// ---- design/lsec_pkg.sv ----
// Types of the LIN slave core: frame states and per-module state records
package lsec_pkg;
  // Frame engine states, one-hot
  typedef enum logic [6:0] {
    ST_IDLE = 7'b000_0001,
    ST_SYNC = 7'b000_0010,
    ST_PID = 7'b000_0100,
    ST_WACK = 7'b000_1000,
    ST_RXD = 7'b001_0000,
    ST_TXD = 7'b010_0000,
    ST_WAKE = 7'b100_0000
  } lsec_state_e;
  // Byte receiver state
  typedef struct packed {
    logic busy;
    logic prev;
    logic [19:0] cnt;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic vld;
    logic ferr;
  } lsec_rx_s;
  // Byte transmitter state
  typedef struct packed {
    logic busy;
    logic [19:0] cnt;
    logic [3:0] bitn;
    logic [9:0] sh;
    logic tx;
  } lsec_tx_s;
endpackage

// ---- design/lsec_rx_byte.sv ----
// Serial byte receiver sampling at mid-bit
`timescale 1ns/1ps
module lsec_rx_byte (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Line and timing
  input wire logic en,
  input wire logic rx,
  input wire logic [19:0] bit_cyc,
  // Received byte
  output logic vld,
  output logic [7:0] dat,
  output logic ferr
);
  lsec_pkg::lsec_rx_s q, n;

  // Next state: start detect, half-bit offset, then one sample per bit
  always_comb begin
    n = q;
    n.prev = rx;
    n.vld = 1'b0;
    if (!q.busy) begin
      if (en && q.prev && !rx) begin
        n.busy = 1'b1;
        n.cnt = {1'b0, bit_cyc[19:1]};
        n.bitn = 4'h0;
      end
    end else if (q.cnt == 20'h0_0000) begin
      n.cnt = bit_cyc - 20'h0_0001;
      n.bitn = q.bitn + 4'h1;
      if (q.bitn == 4'h0) begin
        // False start on a glitch
        if (rx) n.busy = 1'b0;
      end else if (q.bitn <= 4'h8) begin
        n.sh = {rx, q.sh[7:1]};
      end else begin
        // Stop bit
        n.vld = 1'b1;
        n.ferr = !rx;
        n.busy = 1'b0;
      end
    end else begin
      n.cnt = q.cnt - 20'h0_0001;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q <= '0;
      q.prev <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign vld = q.vld;
  assign dat = q.sh;
  assign ferr = q.ferr;
endmodule // lsec_rx_byte

// ---- design/lsec_tx_byte.sv ----
// Serial byte transmitter, start bit, eight data bits, stop bit
`timescale 1ns/1ps
module lsec_tx_byte (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Request
  input wire logic go,
  input wire logic [7:0] dat,
  input wire logic [19:0] bit_cyc,
  // Line and status
  output logic tx,
  output logic busy
);
  lsec_pkg::lsec_tx_s q, n;

  // Next state: shift one frame bit per bit time
  always_comb begin
    n = q;
    if (!q.busy) begin
      if (go) begin
        n.busy = 1'b1;
        n.sh = {1'b1, dat, 1'b0};
        n.bitn = 4'h0;
        n.cnt = bit_cyc - 20'h0_0001;
      end
    end else if (q.cnt == 20'h0_0000) begin
      n.sh = {1'b1, q.sh[9:1]};
      n.bitn = q.bitn + 4'h1;
      n.cnt = bit_cyc - 20'h0_0001;
      if (q.bitn == 4'h9) n.busy = 1'b0;
    end else begin
      n.cnt = q.cnt - 20'h0_0001;
    end
    n.tx = n.busy ? n.sh[0] : 1'b1;
  end

  // State register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q <= '0;
      q.tx <= 1'b1;
      q.sh <= 10'h3FF;
    end else begin
      q <= n;
    end
  end

  assign tx = q.tx;
  assign busy = q.busy;
endmodule // lsec_tx_byte

// ---- design/lsec_core.sv ----
// LIN slave frame engine with sleep, wake-up, errors and indirect register access
`timescale 1ns/1ps
`include "lsec_defines.svh"

// What this block does
// R01 - Slave buffer and ID gated by request, idle
// R02 - Detect header; autobaud measures master bit time
// R03 - Interrupt on identifier, error, completion
// R04 - Identifier received sets request, ID readable
// R05 - Firmware sets direction, length, data, acknowledge
// R06 - Done without request: received bytes readable
// R07 - Firmware answers transmit within response space
// R08 - Early receive byte overwrites buffer, timeout
// R09 - Stop ignores bus until next break
// R10 - Checksum or mode change mid-frame resets
// R11 - Four seconds idle, awake: timeout flag, interrupt
// R12 - Firmware sets sleep after sleep frame
// R13 - Wake request sends wake; master gets done
// R14 - Slave wake: no success interrupt, 150 ms timeout
// R15 - Detected wake sets wakeup, done, interrupt
// R16 - Any error abandons frame, raises interrupt
// R17 - Reset-error clears error register and flag
// R18 - Wake only while error flag clear
// R19 - Firmware ends service clearing interrupt, errors
// R20 - Pointer holds 8-bit core address
// R21 - Data register reads/writes selected core register
// R22 - Acknowledge bit clears itself
// R23 - Reset-interrupt clears flag; strobes read zero
// R24 - Autobaud only in slave mode
// R25 - Unmapped core address reads zero, ignores writes
module lsec_core #(
  parameter int IDLE_CYC = `LSEC_IDLE_S * `LSEC_CLK_MHZ * 1000000,
  parameter int WRESP_CYC = `LSEC_WRESP_MS * `LSEC_CLK_MHZ * 1000,
  parameter int WTX_CYC = `LSEC_WTX_US * `LSEC_CLK_MHZ,
  parameter int WDET_CYC = `LSEC_WDET_US * `LSEC_CLK_MHZ
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // SFR port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // LIN line
  input wire logic lin_rx_i,
  output logic lin_tx_o,
  // Interrupt request
  output logic irq_o
);
  // Whole core state
  typedef struct packed {
    lsec_pkg::lsec_state_e st;
    logic [2:0] rsh;
    logic rxl;
    logic rxp;
    logic [7:0][7:0] dbuf;
    logic [7:0] ptr;
    logic [7:0] cfg;
    logic [7:0] ctrl;
    logic [7:0] stat;
    logic [7:0] err;
    logic [7:0] size;
    logic [7:0] div;
    logic [7:0] mul;
    logic [5:0] id;
    logic [7:0] pid;
    logic [19:0] meas;
    logic meas_ok;
    logic [23:0] cnt;
    logic [23:0] lowc;
    logic [23:0] wrc;
    logic wr_on;
    logic [28:0] idlc;
    logic [3:0] bcnt;
    logic [3:0] idx;
    logic [3:0] nb;
    logic [2:0] falls;
    logic [7:0] csum;
    logic [7:0] txb;
    logic pend;
    logic go;
    logic [7:0] rdata;
    logic txo;
  } lsec_core_s;

  lsec_core_s q, n;
  logic [19:0] bitc; // Active bit time in clocks
  logic [19:0] man_bitc; // Bit time from divider settings
  logic auto_baud_select_on; // Autobaud in force
  logic active; // Bus transfer in progress
  logic acc_ok; // Buffer and ID reachable
  logic rx_vld; // Received byte strobe
  logic [7:0] rx_dat; // Received byte
  logic rx_ferr; // Missing stop bit
  logic rx_en; // Receiver armed
  logic tx_line; // Transmitter line level
  logic tx_busy; // Transmitter sending
  logic [4:0] eset; // Error bits raised this cycle
  logic fr_rst; // Drop current frame
  logic [3:0] len; // Frame length in bytes

  // One's complement carry-wrapping addition
  function automatic logic [7:0] addc(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[7:0] + {7'h00, s[8]};
  endfunction

  // Core register read, zero outside the map or while gated
  function automatic logic [7:0] core_rd(input lsec_core_s c, input logic ok, input logic act);
    logic [7:0] r;
    r = 8'h00;
    if (c.ptr <= `LSEC_A_DBUF_LAST) begin
      if (ok) r = c.dbuf[c.ptr[2:0]]; // R01 R06
    end else begin
      case (c.ptr)
        `LSEC_A_CTRL: r = c.ctrl; // R23
        `LSEC_A_STAT: r = c.stat | {act, 7'h00};
        `LSEC_A_ERR: r = c.err;
        `LSEC_A_SIZE: r = c.size;
        `LSEC_A_DIV: r = c.div;
        `LSEC_A_MUL: r = c.mul;
        `LSEC_A_ID: r = ok ? {2'b00, c.id} : 8'h00; // R04
        default: r = 8'h00; // R25
      endcase
    end
    return r;
  endfunction

  // Bit time: divider times multiplier, scaled by prescaler
  always_comb begin
    man_bitc = 20'(({11'h000, q.mul[0], q.div} * ({15'h0000, q.mul[5:1]} + 20'h0_0001))
               << ({1'b0, q.mul[7:6]} + 3'h1));
    auto_baud_select_on = q.cfg[`LSEC_CFG_AUTO_BAUD_SELECT] && !q.cfg[`LSEC_CFG_MODE]; // R24
    bitc = (auto_baud_select_on && q.meas_ok) ? q.meas : man_bitc; // R02
    active = !(q.st == lsec_pkg::ST_IDLE || q.st == lsec_pkg::ST_WACK);
    acc_ok = q.cfg[`LSEC_CFG_MODE] || (!active &&
             (q.stat[`LSEC_ST_DATA_REQUEST_FLAG] || q.stat[`LSEC_ST_DONE])); // R01 R06
    rx_en = q.cfg[`LSEC_CFG_EN] && !(q.st == lsec_pkg::ST_SYNC && auto_baud_select_on);
    if (q.size[3:0] == `LSEC_SZ_DECODE) begin
      len = (q.id[5:4] == 2'b11) ? 4'h8 : (q.id[5:4] == 2'b10) ? 4'h4 : 4'h2;
    end else begin
      len = q.size[3:0];
    end
  end

  // Byte receiver, also hears our own transmissions
  lsec_rx_byte u_rx (
    .clk(clk),
    .sys_rst(sys_rst),
    .en(rx_en),
    .rx(q.rxl),
    .bit_cyc(bitc),
    .vld(rx_vld),
    .dat(rx_dat),
    .ferr(rx_ferr)
  );

  // Byte transmitter for slave responses
  lsec_tx_byte u_tx (
    .clk(clk),
    .sys_rst(sys_rst),
    .go(q.go),
    .dat(q.txb),
    .bit_cyc(bitc),
    .tx(tx_line),
    .busy(tx_busy)
  );

  // Next state of the whole core
  always_comb begin
    n = q;
    eset = 5'h00;
    fr_rst = 1'b0;
    // Line synchroniser, change accepted when last two stages agree
    n.rsh = {q.rsh[1:0], lin_rx_i};
    if (q.rsh[1] == q.rsh[2]) n.rxl = q.rsh[2];
    n.rxp = q.rxl;
    n.go = 1'b0;
    // Acknowledge bit clears itself outside the wait
    if (q.st != lsec_pkg::ST_WACK) n.ctrl[`LSEC_CT_DATA_ACK_BIT] = 1'b0; // R22

    // SFR writes
    if (sfr_wr) begin
      case (sfr_addr)
        `LSEC_SFR_PTR: n.ptr = sfr_wdata; // R20
        `LSEC_SFR_CFG: begin
          n.cfg = sfr_wdata & `LSEC_CFG_MASK;
          // Mode flip mid-frame drops the frame
          if ((active || q.stat[`LSEC_ST_DATA_REQUEST_FLAG]) &&
              sfr_wdata[`LSEC_CFG_MODE] != q.cfg[`LSEC_CFG_MODE]) fr_rst = 1'b1; // R10
        end
        `LSEC_SFR_DATA: begin
          // Indirect write to the selected core register
          if (q.ptr <= `LSEC_A_DBUF_LAST) begin
            if (acc_ok) n.dbuf[q.ptr[2:0]] = sfr_wdata; // R01 R21
          end else begin
            case (q.ptr)
              `LSEC_A_CTRL: begin
                n.ctrl = (sfr_wdata & `LSEC_CT_MASK) | (q.ctrl & ~`LSEC_CT_MASK);
                // Acknowledge only meaningful in slave mode
                if (!q.cfg[`LSEC_CFG_MODE]) n.ctrl[`LSEC_CT_DATA_ACK_BIT] = sfr_wdata[`LSEC_CT_DATA_ACK_BIT];
                // Wake request refused while an error stands
                if (sfr_wdata[`LSEC_CT_WAKE_REQUEST_BIT] && !q.stat[`LSEC_ST_ERROR]) begin
                  n.ctrl[`LSEC_CT_WAKE_REQUEST_BIT] = 1'b1; // R18
                end
                if (sfr_wdata[`LSEC_CT_CLEAR_INTERRUPT_BIT]) n.stat[`LSEC_ST_INT] = 1'b0; // R23 R19
                if (sfr_wdata[`LSEC_CT_CLEAR_ERRORS_BIT]) begin
                  n.err = 8'h00; // R17
                  n.stat[`LSEC_ST_ERROR] = 1'b0; // R17
                end
              end
              `LSEC_A_SIZE: begin
                n.size = sfr_wdata;
                // Checksum type change mid-frame drops the frame
                if ((active || q.stat[`LSEC_ST_DATA_REQUEST_FLAG]) &&
                    sfr_wdata[`LSEC_SZ_ENH] != q.size[`LSEC_SZ_ENH]) fr_rst = 1'b1; // R10
              end
              `LSEC_A_DIV: n.div = sfr_wdata;
              `LSEC_A_MUL: n.mul = sfr_wdata;
              `LSEC_A_ID: if (acc_ok) n.id = sfr_wdata[5:0]; // R01
              default: n.id = n.id; // R25
            endcase
          end
        end
        default: n.ptr = n.ptr;
      endcase
    end

    // Frame engine
    if (!q.cfg[`LSEC_CFG_EN]) begin
      n.st = lsec_pkg::ST_IDLE;
      n.pend = 1'b0;
      n.wr_on = 1'b0;
    end else begin
      case (q.st)
        lsec_pkg::ST_IDLE: begin
          // Measure dominant time: bits for a break, clocks for a wake pulse
          if (!q.rxl) begin
            if (q.lowc != 24'hFF_FFFF) n.lowc = q.lowc + 24'h00_0001;
            if (q.cnt[19:0] >= bitc - 20'h0_0001) begin
              n.cnt = 24'h00_0000;
              if (q.bcnt != `LSEC_BRK_BITS) n.bcnt = q.bcnt + 4'h1;
            end else begin
              n.cnt = q.cnt + 24'h00_0001;
            end
          end else begin
            n.lowc = 24'h00_0000;
            n.cnt = 24'h00_0000;
            n.bcnt = 4'h0;
            if (!q.rxp && q.ctrl[`LSEC_CT_SLEEP] && q.lowc >= 24'(WDET_CYC)) begin
              n.stat[`LSEC_ST_WAKEUP] = 1'b1; // R15
              n.stat[`LSEC_ST_DONE] = 1'b1; // R15
              n.stat[`LSEC_ST_INT] = 1'b1; // R15
            end else if (!q.rxp && q.bcnt == `LSEC_BRK_BITS) begin
              // Break seen: header starts, any stop is over
              n.st = lsec_pkg::ST_SYNC; // R02 R09
              n.falls = 3'h0;
              n.wr_on = 1'b0;
              n.stat[`LSEC_ST_DONE] = 1'b0;
            end else if (q.ctrl[`LSEC_CT_WAKE_REQUEST_BIT]) begin
              n.st = lsec_pkg::ST_WAKE; // R13
            end
          end
        end
        lsec_pkg::ST_SYNC: begin
          if (auto_baud_select_on) begin
            // Time eight bits between first and fifth falling edge
            if (q.falls != 3'h0) n.cnt = q.cnt + 24'h00_0001;
            if (!q.rxl && q.rxp) begin
              n.falls = q.falls + 3'h1;
              if (q.falls == 3'h0) n.cnt = 24'h00_0000;
              if (q.falls == `LSEC_SYNC_FALLS) begin
                n.meas = q.cnt[22:3]; // R02
                n.meas_ok = 1'b1;
                n.st = lsec_pkg::ST_PID;
              end
            end
            if (q.cnt == 24'hFF_FFFF) eset[`LSEC_ER_SYNCH] = 1'b1;
          end else if (rx_vld) begin
            // Fixed rate: the byte must be the sync pattern
            if (rx_ferr || rx_dat != `LSEC_SYNC_PAT) eset[`LSEC_ER_SYNCH] = 1'b1; // R02
            else n.st = lsec_pkg::ST_PID;
          end
        end
        lsec_pkg::ST_PID: begin
          if (rx_vld) begin
            n.pid = rx_dat;
            n.id = rx_dat[5:0]; // R04
            if (rx_dat[6] != ^{rx_dat[4], rx_dat[2:0]} ||
                rx_dat[7] != ~^{rx_dat[5:3], rx_dat[1]}) begin
              eset[`LSEC_ER_PRTY] = 1'b1;
            end else begin
              n.stat[`LSEC_ST_DATA_REQUEST_FLAG] = 1'b1; // R04
              n.stat[`LSEC_ST_INT] = 1'b1; // R03
              n.st = lsec_pkg::ST_WACK;
            end
          end
        end
        lsec_pkg::ST_WACK: begin
          if (sfr_wr && sfr_addr == `LSEC_SFR_DATA && q.ptr == `LSEC_A_CTRL &&
              sfr_wdata[`LSEC_CT_STOP] && !q.cfg[`LSEC_CFG_MODE]) begin
            // Unknown identifier: drop the frame, wait for a break
            n.stat[`LSEC_ST_DATA_REQUEST_FLAG] = 1'b0; // R09
            n.st = lsec_pkg::ST_IDLE; // R09
          end else if (q.ctrl[`LSEC_CT_DATA_ACK_BIT]) begin
            n.ctrl[`LSEC_CT_DATA_ACK_BIT] = 1'b0; // R22
            n.stat[`LSEC_ST_DATA_REQUEST_FLAG] = 1'b0;
            n.nb = len;
            n.idx = 4'h0;
            n.csum = q.size[`LSEC_SZ_ENH] ? q.pid : 8'h00;
            if (q.ctrl[`LSEC_CT_DIRECTION_SELECT]) begin
              n.txb = q.dbuf[0];
              n.csum = addc(q.size[`LSEC_SZ_ENH] ? q.pid : 8'h00, q.dbuf[0]);
              n.pend = 1'b1;
              n.st = lsec_pkg::ST_TXD;
            end else begin
              n.st = lsec_pkg::ST_RXD;
            end
          end else if (rx_vld) begin
            // Byte arrived before the set-up finished
            n.dbuf[0] = rx_dat; // R08
            eset[`LSEC_ER_TIMEOUT_ERROR_BIT] = 1'b1; // R08
          end
        end
        lsec_pkg::ST_RXD: begin
          if (rx_vld) begin
            if (q.idx != q.nb) begin
              n.dbuf[q.idx[2:0]] = rx_dat; // R06
              n.csum = addc(q.csum, rx_dat);
              n.idx = q.idx + 4'h1;
            end else if (addc(q.csum, rx_dat) == `LSEC_CSUM_OK) begin
              n.stat[`LSEC_ST_DONE] = 1'b1; // R06
              n.stat[`LSEC_ST_INT] = 1'b1; // R03
              n.st = lsec_pkg::ST_IDLE;
            end else begin
              eset[`LSEC_ER_CHK] = 1'b1;
            end
          end
        end
        lsec_pkg::ST_TXD: begin
          // Each echoed byte is checked, then the next is queued
          if (rx_vld) begin
            if (rx_dat != q.txb || rx_ferr) begin
              eset[`LSEC_ER_BIT] = 1'b1;
            end else if (q.idx + 4'h1 < q.nb) begin
              n.idx = q.idx + 4'h1;
              n.txb = q.dbuf[3'(q.idx + 4'h1)];
              n.csum = addc(q.csum, q.dbuf[3'(q.idx + 4'h1)]);
              n.pend = 1'b1;
            end else if (q.idx + 4'h1 == q.nb) begin
              n.idx = q.idx + 4'h1;
              n.txb = ~q.csum;
              n.pend = 1'b1;
            end else begin
              n.stat[`LSEC_ST_DONE] = 1'b1;
              n.stat[`LSEC_ST_INT] = 1'b1; // R03
              n.st = lsec_pkg::ST_IDLE;
            end
          end
        end
        lsec_pkg::ST_WAKE: begin
          // Hold the line dominant for the wake pulse
          n.cnt = q.cnt + 24'h00_0001;
          if (q.cnt >= 24'(WTX_CYC - 1)) begin
            n.cnt = 24'h00_0000;
            n.ctrl[`LSEC_CT_WAKE_REQUEST_BIT] = 1'b0;
            n.st = lsec_pkg::ST_IDLE;
            if (q.cfg[`LSEC_CFG_MODE]) begin
              n.stat[`LSEC_ST_DONE] = 1'b1; // R13
              n.stat[`LSEC_ST_INT] = 1'b1; // R13
            end else begin
              n.wr_on = 1'b1; // R14
              n.wrc = 24'h00_0000;
            end
          end
        end
        default: n.st = lsec_pkg::ST_IDLE;
      endcase
    end

    // Slave wake: master must answer with a break in time
    if (q.wr_on && n.wr_on) begin
      n.wrc = q.wrc + 24'h00_0001;
      if (q.wrc >= 24'(WRESP_CYC - 1)) begin
        n.wr_on = 1'b0;
        eset[`LSEC_ER_TIMEOUT_ERROR_BIT] = 1'b1; // R14
      end
    end

    // Bus idle watch while awake
    if (q.cfg[`LSEC_CFG_EN] && !q.ctrl[`LSEC_CT_SLEEP] && q.st == lsec_pkg::ST_IDLE &&
        q.rxl == q.rxp) begin
      if (q.idlc != 29'(IDLE_CYC - 1)) n.idlc = q.idlc + 29'h0000_0001;
      if (q.idlc == 29'(IDLE_CYC - 2)) begin
        n.stat[`LSEC_ST_IDL] = 1'b1; // R11
        n.stat[`LSEC_ST_INT] = 1'b1; // R11
      end
    end else begin
      n.idlc = 29'h0000_0000;
    end

    // Any error abandons the frame and requests service
    if (eset != 5'h00) begin
      n.err = n.err | {3'h0, eset}; // R16
      n.stat[`LSEC_ST_ERROR] = 1'b1; // R16
      n.stat[`LSEC_ST_INT] = 1'b1; // R03 R16
      n.stat[`LSEC_ST_DATA_REQUEST_FLAG] = 1'b0;
      n.pend = 1'b0;
      n.st = lsec_pkg::ST_IDLE; // R16
    end

    // Configuration change mid-frame resets the interface
    if (fr_rst) begin
      n.st = lsec_pkg::ST_IDLE; // R10
      n.stat[`LSEC_ST_DATA_REQUEST_FLAG] = 1'b0; // R10
      n.pend = 1'b0;
    end

    // Hand a queued byte to the transmitter
    if (q.pend && !tx_busy && !q.go) begin
      n.go = 1'b1;
      n.pend = 1'b0;
    end

    // Registered outputs
    n.txo = (q.st == lsec_pkg::ST_WAKE) ? 1'b0 : tx_line;
    case (sfr_addr)
      `LSEC_SFR_PTR: n.rdata = q.ptr;
      `LSEC_SFR_CFG: n.rdata = q.cfg;
      `LSEC_SFR_DATA: n.rdata = core_rd(q, acc_ok, active); // R21
      default: n.rdata = 8'h00;
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q <= '0;
      q.st <= lsec_pkg::ST_IDLE;
      q.cfg <= `LSEC_CFG_RST;
      q.rsh <= 3'h7;
      q.rxl <= 1'b1;
      q.rxp <= 1'b1;
      q.txo <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign sfr_rdata = q.rdata;
  assign lin_tx_o = q.txo;
  assign irq_o = q.stat[`LSEC_ST_INT]; // R03
endmodule // lsec_core

// ---- sim/lsec_monitor.sv ----
// Port checker for the LIN slave core, bound to its top module
`timescale 1ns/1ps
module lsec_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // SFR port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  // Line and interrupt
  input wire logic lin_rx_i,
  input wire logic lin_tx_o,
  input wire logic irq_o
);
  logic [7:0] ptr_q; // Shadow of the indirect pointer
  logic ctl_w; // Write to the control register
  logic clr_int; // Interrupt clear strobe
  assign ctl_w = sfr_wr && sfr_addr == 8'hD2 && ptr_q == 8'h08;
  assign clr_int = ctl_w && sfr_wdata[3];
  // Pointer shadow follows pointer writes
  always_ff @(posedge clk) begin
    if (sys_rst) ptr_q <= 8'h00;
    else if (sfr_wr && sfr_addr == 8'hD3) ptr_q <= sfr_wdata;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  rst_quiet_a: assert property (disable iff (1'b0) sys_rst |=> sfr_rdata == 8'h00 && lin_tx_o && !irq_o) else $error("reset outputs wrong");
  ptr_back_a: assert property (sfr_wr && sfr_addr == 8'hD3 ##1 !sfr_wr && sfr_addr == 8'hD3 |=> sfr_rdata == $past(sfr_wdata, 2)) else $error("pointer readback wrong");
  sfr_hole_a: assert property (!(sfr_addr inside {8'hD2, 8'hD3, 8'hC9}) |=> sfr_rdata == 8'h00) else $error("unmapped read not zero");
  mode_low_a: assert property (sfr_addr == 8'hC9 |=> sfr_rdata[4:0] == 5'h00) else $error("mode low bits set");
  ctl_zero_a: assert property (!sfr_wr && sfr_addr == 8'hD2 && ptr_q == 8'h08 |=> !sfr_rdata[7] && sfr_rdata[3:2] == 2'h0) else $error("strobe bit reads one");
  int_clear_a: assert property (clr_int |=> !irq_o) else $error("interrupt not cleared");
  int_fall_a: assert property ($fell(irq_o) |-> $past(clr_int)) else $error("interrupt dropped alone");
  err_clear_a: assert property (ctl_w && sfr_wdata[2] ##1 sfr_wr && sfr_addr == 8'hD3 && sfr_wdata == 8'h0A ##1 !sfr_wr && sfr_addr == 8'hD2 |=> sfr_rdata == 8'h00) else $error("errors not cleared");
  // Main scenarios
  cover property ($rose(irq_o));
  cover property ($fell(lin_tx_o));
  cover property (clr_int);
endmodule // lsec_monitor

bind lsec_core lsec_monitor i_lsec_monitor (.clk(clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr),
  .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .lin_rx_i(lin_rx_i),
  .lin_tx_o(lin_tx_o), .irq_o(irq_o));

// ---- sim/lsec_master_model.sv ----
// Behavioural LIN master driving the shared line
`timescale 1ns/1ps
module lsec_master_model #(
  parameter int BIT = 20
) (
  // Clock
  input wire logic clk,
  // Line drive, 0 dominant
  output logic line
);
  initial line = 1'b1; // Recessive at rest, pulled up
  // Dominant for n clocks, then release
  task automatic low(input int n);
    line = 1'b0;
    repeat (n) @(negedge clk);
    line = 1'b1;
  endtask
  // Break longer than eleven bits, then delimiter
  task automatic brk();
    low(13 * BIT);
    repeat (BIT) @(negedge clk);
  endtask
  // Start bit, eight bits LSB first, stop bit
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line = f[i];
      repeat (BIT) @(negedge clk);
    end
  endtask
endmodule // lsec_master_model

// ---- sim/lsec_core_bench.sv ----
// Self-checking bench for the LIN slave core
`timescale 1ns/1ps
module lsec_core_bench;
  logic clk, sys_rst, sfr_wr, mline;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, v;
  logic lin_rx, lin_tx_o, irq_o;
  int errors, checks;
  assign lin_rx = mline & lin_tx_o; // Wired-AND bus
  // Short counts keep the run brief; wake answer time stays below the idle time
  localparam int IDLE_T = 2000, WRESP_T = 1000, WTX_T = 200, WDET_T = 100, BIT_T = 20;
  lsec_core #(.IDLE_CYC(IDLE_T), .WRESP_CYC(WRESP_T), .WTX_CYC(WTX_T), .WDET_CYC(WDET_T))
    i_lsec_core (
    .clk(clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .lin_rx_i(lin_rx), .lin_tx_o(lin_tx_o), .irq_o(irq_o));
  lsec_master_model #(.BIT(BIT_T)) i_lsec_master_model (.clk(clk), .line(mline));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic cyc(input int n);
    sfr_wr = 1'b0;
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    sfr_wr = 1'b0;
    sfr_addr = a;
    @(negedge clk);
    d = sfr_rdata;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic iw(input logic [7:0] p, input logic [7:0] d);
    wr(8'hD3, p);
    wr(8'hD2, d);
  endtask
  task automatic ir(input logic [7:0] p, input logic [7:0] m, input logic [7:0] e);
    wr(8'hD3, p);
    rd(8'hD2, v);
    chk(v & m, e);
  endtask
  // Bounded wait for the interrupt line
  task automatic wirq();
    cyc(1);
    for (int i = 0; i < 4000 && irq_o !== 1'b1; i++) @(negedge clk);
    chk({7'h00, irq_o}, 8'h01);
  endtask
  // Break, sync and the protected identifier 0x11, bus strobe released first
  task automatic hdr();
    cyc(1);
    i_lsec_master_model.brk();
    i_lsec_master_model.send(8'h55);
    i_lsec_master_model.send(8'h11);
  endtask
  task automatic test_done();
    if (errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Watchdog
  initial begin
    #300000;
    errors++;
    test_done();
  end
  // Main sequence
  initial begin
    sys_rst = 1'b1;
    sfr_wr = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    errors = 0;
    checks = 0;
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    cyc(4);
    rd(8'hC9, v); chk(v, 8'h60);
    rd(8'hD3, v); chk(v, 8'h00);
    wr(8'hC9, 8'h80);
    iw(8'h0D, 8'h00);
    iw(8'h0C, 8'h0A);
    ir(8'h0C, 8'hFF, 8'h0A);
    wr(8'hD3, 8'h3C); rd(8'hD3, v); chk(v, 8'h3C);
    iw(8'h3C, 8'h5A); ir(8'h3C, 8'hFF, 8'h00);
    iw(8'h00, 8'h5A); ir(8'h00, 8'hFF, 8'h00);
    iw(8'h08, 8'hEC); ir(8'h08, 8'hFF, 8'h60);
    iw(8'h08, 8'h00);
    wirq(); ir(8'h09, 8'h48, 8'h48);
    iw(8'h08, 8'h0C); chk({7'h00, irq_o}, 8'h00);
    hdr();
    wirq(); ir(8'h09, 8'h10, 8'h10);
    ir(8'h0E, 8'hFF, 8'h11);
    iw(8'h08, 8'h08);
    cyc(1);
    i_lsec_master_model.send(8'hA5);
    wirq(); ir(8'h0A, 8'hFF, 8'h04);
    ir(8'h09, 8'h04, 8'h04);
    iw(8'h08, 8'h0C); wr(8'hD3, 8'h0A); rd(8'hD2, v); chk(v, 8'h00);
    ir(8'h09, 8'h04, 8'h00);
    hdr(); wirq(); iw(8'h0B, 8'h02); iw(8'h08, 8'h18);
    cyc(1);
    i_lsec_master_model.send(8'h12);
    i_lsec_master_model.send(8'h34);
    i_lsec_master_model.send(8'hB9);
    wirq(); ir(8'h09, 8'h11, 8'h01); ir(8'h01, 8'hFF, 8'h34);
    iw(8'h08, 8'h08);
    hdr(); wirq(); iw(8'h08, 8'h38);
    wirq(); ir(8'h09, 8'h15, 8'h01);
    iw(8'h08, 8'h0A); cyc(10); chk({7'h00, lin_tx_o}, 8'h00);
    cyc(250); chk({6'h00, lin_tx_o, irq_o}, 8'h02);
    wirq(); ir(8'h0A, 8'hFF, 8'h04);
    iw(8'h08, 8'h0A); cyc(10); chk({7'h00, lin_tx_o}, 8'h01);
    iw(8'h08, 8'h0C);
    iw(8'h08, 8'h40);
    cyc(1);
    i_lsec_master_model.low(150);
    wirq(); ir(8'h09, 8'h0B, 8'h0B);
    test_done();
  end
endmodule // lsec_core_bench
